// file: shared/synth_cal_test_pkg.sv
// constants and carrier types for the synthesizer calibration and test register bank
// assumes a byte-wide register port decoded from the serial interface upstream
package synth_cal_test_pkg;

    // register addresses
    localparam logic [5:0] VCO_COARSE_CAP_RESULT_ADDR = 6'h25;
    localparam logic [5:0] SYNTH_CAL_CONTROL_ADDR = 6'h26;
    localparam logic [5:0] ANALOG_TRIM_A_ADDR = 6'h29;
    localparam logic [5:0] ANALOG_TRIM_B_ADDR = 6'h2A;
    localparam logic [5:0] ANALOG_TRIM_C_ADDR = 6'h2B;
    localparam logic [5:0] WAKE_FORCED_SETTING_HI_ADDR = 6'h2C;
    localparam logic [5:0] WAKE_FORCED_SETTING_LO_ADDR = 6'h2D;
    localparam logic [5:0] VCO_SELECT_CAL_SETTING_ADDR = 6'h2E;

    // field layouts
    localparam int CAP_WIDTH = 6;
    localparam int CTRL_WIDTH = 7;
    localparam int VCO_SEL_CAL_BIT = 1;
    localparam int CHP_FIELD_LSB = 4;

    // reset values
    localparam logic [5:0] VCO_COARSE_CAP_RESET = 6'h20;
    localparam logic [6:0] SYNTH_CAL_CONTROL_RESET = 7'h0D;
    localparam logic [7:0] ANALOG_TRIM_A_RESET = 8'h59;
    localparam logic [7:0] ANALOG_TRIM_B_RESET = 8'h7F;
    localparam logic [7:0] ANALOG_TRIM_C_RESET = 8'h3F;
    localparam logic [7:0] WAKE_HI_RESET = 8'h88;
    localparam logic [7:0] WAKE_LO_RESET = 8'h31;
    localparam logic [7:0] VCO_SELECT_CAL_RESET = 8'h0B;

    // values forced into the analog section on wake
    localparam logic [7:0] WAKE_HI_KEEP_OFF = 8'h88;
    localparam logic [7:0] WAKE_HI_KEEP_ON = 8'h81;
    localparam logic [7:0] WAKE_LO_KEEP_OFF = 8'h31;
    localparam logic [7:0] WAKE_LO_KEEP_ON = 8'h35;

    // one register port access
    typedef struct packed {
        logic write;
        logic read;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // readback answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } reg_rsp_type;

endpackage : synth_cal_test_pkg

// file: src/synth_cal_test_regs.sv
// synthesizer calibration, analog trim and test setting register bank
// assumes regReq and sleepActive come from logic on core_clk
//
// Behaviour
// - 6-bit rw VCO coarse cap result in bits 5:0, resets 0x20, bits 7:6 read zero.
// - 7-bit rw synth calibration control in bits 6:0, resets 0x0D, bit 7 zero.
// - registers from 0x29 upward lose contents in sleep; host reprograms them.
// - trim bytes 0x29, 0x2A, 0x2B reset to 0x59, 0x7F, 0x3F.
// - on wake second test byte is forced internally to 0x88 or 0x81 by keep option.
// - after wake second test byte reads 0x88 regardless of keep option.
// - on wake first test byte is forced internally to 0x31 or 0x35 by keep option.
// - after wake first test byte reads 0x31 regardless of keep option.
// - bit 1 of third test byte enables VCO selection calibration, resets to 1.
// - third test byte has 2-bit charge pump field; bits 7:2 reset 000010, bit 0 one.
`timescale 1ns/1ns
module synth_cal_test_regs
    import synth_cal_test_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire reg_req_type regReq,
    input wire logic sleepActive,
    input wire logic converterKeepOption,
    output reg_rsp_type regRsp,
    output logic [5:0] vcoCoarseCap,
    output logic [6:0] synthCalControl,
    output logic [7:0] analogTrimA,
    output logic [7:0] analogTrimB,
    output logic [7:0] analogTrimC,
    output logic [7:0] wakeHiAnalog,
    output logic [7:0] wakeLoAnalog,
    output logic [7:0] vcoSelectCalSetting,
    output logic vcoSelectionCalEnable,
    output logic [1:0] chargePumpCalField
);

    // ====================================================================
    // wake detection
    logic sleepPrev_reg;
    logic wakePulse;
    logic writeOk;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sleepPrev_reg <= 1'b0;
        end else begin
            sleepPrev_reg <= sleepActive;
        end
    end

    assign wakePulse = sleepPrev_reg & ~sleepActive;
    // no writes land while asleep; the wake reload wins over a same-cycle write
    assign writeOk = regReq.write & ~sleepActive & ~wakePulse;

    function automatic logic hit(input logic [5:0] a);
        hit = writeOk && (regReq.addr == a);
    endfunction : hit

    // ====================================================================
    // retained calibration registers
    logic [5:0] capReg;
    logic [6:0] ctrlReg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            capReg <= VCO_COARSE_CAP_RESET;
        end else if (hit(VCO_COARSE_CAP_RESULT_ADDR)) begin
            capReg <= regReq.wdata[CAP_WIDTH-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrlReg <= SYNTH_CAL_CONTROL_RESET;
        end else if (hit(SYNTH_CAL_CONTROL_ADDR)) begin
            ctrlReg <= regReq.wdata[CTRL_WIDTH-1:0];
        end
    end

    // ====================================================================
    // registers lost in sleep, reloaded on wake
    logic [7:0] trimAReg;
    logic [7:0] trimBReg;
    logic [7:0] trimCReg;
    logic [7:0] hiReg;
    logic [7:0] loReg;
    logic [7:0] selReg;
    logic [7:0] hiAnalogReg;
    logic [7:0] loAnalogReg;

    always_ff @(posedge core_clk) begin
        if (sys_rst || wakePulse) begin
            trimAReg <= ANALOG_TRIM_A_RESET;
            trimBReg <= ANALOG_TRIM_B_RESET;
            trimCReg <= ANALOG_TRIM_C_RESET;
            selReg <= VCO_SELECT_CAL_RESET;
        end else begin
            if (hit(ANALOG_TRIM_A_ADDR)) begin
                trimAReg <= regReq.wdata;
            end
            if (hit(ANALOG_TRIM_B_ADDR)) begin
                trimBReg <= regReq.wdata;
            end
            if (hit(ANALOG_TRIM_C_ADDR)) begin
                trimCReg <= regReq.wdata;
            end
            if (hit(VCO_SELECT_CAL_SETTING_ADDR)) begin
                selReg <= regReq.wdata;
            end
        end
    end

    // readback copies show the reset values after wake
    always_ff @(posedge core_clk) begin
        if (sys_rst || wakePulse) begin
            hiReg <= WAKE_HI_RESET;
            loReg <= WAKE_LO_RESET;
        end else begin
            if (hit(WAKE_FORCED_SETTING_HI_ADDR)) begin
                hiReg <= regReq.wdata;
            end
            if (hit(WAKE_FORCED_SETTING_LO_ADDR)) begin
                loReg <= regReq.wdata;
            end
        end
    end

    // analog copies take the keep-option dependent value on wake
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hiAnalogReg <= WAKE_HI_RESET;
            loAnalogReg <= WAKE_LO_RESET;
        end else if (wakePulse) begin
            hiAnalogReg <= converterKeepOption ? WAKE_HI_KEEP_ON : WAKE_HI_KEEP_OFF;
            loAnalogReg <= converterKeepOption ? WAKE_LO_KEEP_ON : WAKE_LO_KEEP_OFF;
        end else begin
            if (hit(WAKE_FORCED_SETTING_HI_ADDR)) begin
                hiAnalogReg <= regReq.wdata;
            end
            if (hit(WAKE_FORCED_SETTING_LO_ADDR)) begin
                loAnalogReg <= regReq.wdata;
            end
        end
    end

    // ====================================================================
    // readback
    logic [7:0] readMux;

    always_comb begin
        case (regReq.addr)
            VCO_COARSE_CAP_RESULT_ADDR: readMux = {2'b00, capReg};
            SYNTH_CAL_CONTROL_ADDR: readMux = {1'b0, ctrlReg};
            ANALOG_TRIM_A_ADDR: readMux = trimAReg;
            ANALOG_TRIM_B_ADDR: readMux = trimBReg;
            ANALOG_TRIM_C_ADDR: readMux = trimCReg;
            WAKE_FORCED_SETTING_HI_ADDR: readMux = hiReg;
            WAKE_FORCED_SETTING_LO_ADDR: readMux = loReg;
            VCO_SELECT_CAL_SETTING_ADDR: readMux = selReg;
            default: readMux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRsp <= '0;
        end else begin
            regRsp.valid <= regReq.read;
            regRsp.data <= regReq.read ? readMux : 8'h00;
        end
    end

    // ====================================================================
    // outputs
    assign vcoCoarseCap = capReg;
    assign synthCalControl = ctrlReg;
    assign analogTrimA = trimAReg;
    assign analogTrimB = trimBReg;
    assign analogTrimC = trimCReg;
    assign wakeHiAnalog = hiAnalogReg;
    assign wakeLoAnalog = loAnalogReg;
    assign vcoSelectCalSetting = selReg;
    assign vcoSelectionCalEnable = selReg[VCO_SEL_CAL_BIT];
    assign chargePumpCalField = selReg[CHP_FIELD_LSB+1:CHP_FIELD_LSB];

    // ====================================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_cap_write_low: assert property (
        hit(VCO_COARSE_CAP_RESULT_ADDR) |=> capReg == $past(regReq.wdata[5:0]))
        else $error("cap result write not stored");
    a_cap_read_zero: assert property (
        regReq.read && regReq.addr == VCO_COARSE_CAP_RESULT_ADDR
        |=> regRsp.valid && regRsp.data[7:6] == 2'b00 && regRsp.data[5:0] == $past(capReg))
        else $error("cap result readback wrong");
    a_ctrl_read_zero: assert property (
        regReq.read && regReq.addr == SYNTH_CAL_CONTROL_ADDR
        |=> regRsp.data == {1'b0, $past(ctrlReg)})
        else $error("cal control readback wrong");
    a_trim_wake_lost: assert property (
        wakePulse |=> trimAReg == 8'h59 && trimBReg == 8'h7F && trimCReg == 8'h3F)
        else $error("trim bytes not reloaded on wake");
    a_hi_wake_force: assert property (
        wakePulse |=> wakeHiAnalog == ($past(converterKeepOption) ? 8'h81 : 8'h88))
        else $error("hi test byte not forced on wake");
    a_hi_wake_read: assert property (
        wakePulse ##1 (regReq.read && regReq.addr == WAKE_FORCED_SETTING_HI_ADDR
        && !regReq.write) |=> regRsp.data == 8'h88)
        else $error("hi test byte reads wrong after wake");
    a_lo_wake_force: assert property (
        wakePulse |=> wakeLoAnalog == ($past(converterKeepOption) ? 8'h35 : 8'h31))
        else $error("lo test byte not forced on wake");
    a_lo_wake_read: assert property (
        wakePulse |=> loReg == 8'h31)
        else $error("lo test byte readback not reset value after wake");
    a_sel_wake_reset: assert property (
        wakePulse |=> vcoSelectionCalEnable && vcoSelectCalSetting == 8'h0B
        && chargePumpCalField == 2'b00)
        else $error("vco select setting not reloaded");
    a_sleep_no_write: assert property (
        sleepActive |=> $stable(trimAReg) && $stable(capReg))
        else $error("register changed while asleep");

endmodule : synth_cal_test_regs

// file: test/synth_cal_test_regs_tb.sv
// self-checking bench for the synthesizer calibration and test register bank
// assumes the byte-wide register port and sleep level are driven on core_clk
`timescale 1ns/1ns
module synth_cal_test_regs_tb
    import synth_cal_test_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst;
    reg_req_type regReq;
    logic sleepActive;
    logic converterKeepOption;
    reg_rsp_type regRsp;
    logic [5:0] vcoCoarseCap;
    logic [6:0] synthCalControl;
    logic [7:0] analogTrimA;
    logic [7:0] analogTrimB;
    logic [7:0] analogTrimC;
    logic [7:0] wakeHiAnalog;
    logic [7:0] wakeLoAnalog;
    logic [7:0] vcoSelectCalSetting;
    logic vcoSelectionCalEnable;
    logic [1:0] chargePumpCalField;
    int failures = 0;
    int nCompared = 0;
    logic [5:0] addrs [8] = '{6'h25, 6'h26, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e};
    logic [7:0] rstVals [8] = '{8'h20, 8'h0d, 8'h59, 8'h7f, 8'h3f, 8'h88, 8'h31, 8'h0b};

    synth_cal_test_regs i_synth_cal_test_regs (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .regReq(regReq),
        .sleepActive(sleepActive),
        .converterKeepOption(converterKeepOption),
        .regRsp(regRsp),
        .vcoCoarseCap(vcoCoarseCap),
        .synthCalControl(synthCalControl),
        .analogTrimA(analogTrimA),
        .analogTrimB(analogTrimB),
        .analogTrimC(analogTrimC),
        .wakeHiAnalog(wakeHiAnalog),
        .wakeLoAnalog(wakeLoAnalog),
        .vcoSelectCalSetting(vcoSelectCalSetting),
        .vcoSelectionCalEnable(vcoSelectionCalEnable),
        .chargePumpCalField(chargePumpCalField)
    );

    always #4 core_clk = ~core_clk;

    // =====================================
    // access and compare tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regReq.write = 1'b1;
        regReq.addr = a;
        regReq.wdata = d;
        @(negedge core_clk);
        regReq.write = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        regReq.read = 1'b1;
        regReq.addr = a;
        @(negedge core_clk);
        regReq.read = 1'b0;
        chk({7'h0, regRsp.valid}, 8'h01);
        chk(regRsp.data, exp);
    endtask : rd

    task automatic stop_test();
        $display("compares %0d mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // =====================================
    // watchdog
    initial begin
        #20000;
        failures++;
        $display("BAD %0t run did not finish", $time);
        stop_test();
    end

    // =====================================
    // tests
    initial begin
        regReq = '0;
        sleepActive = 1'b0;
        converterKeepOption = 1'b0;
        sys_rst = 1'b1;
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(addrs[i], rstVals[i]);
        end
        chk({7'h0, vcoSelectionCalEnable}, 8'h01);
        rd(6'h27, 8'h00);
        $display("reset values done");
        wr(6'h25, 8'hff);
        rd(6'h25, 8'h3f);
        wr(6'h26, 8'hff);
        rd(6'h26, 8'h7f);
        chk({1'b0, synthCalControl}, 8'h7f);
        wr(6'h26, {1'b0, SYNTH_CAL_CONTROL_RESET});
        rd(6'h26, 8'h0d);
        $display("unused bits done");
        wr(6'h2e, 8'h31);
        chk({7'h0, vcoSelectionCalEnable}, 8'h00);
        chk({6'h0, chargePumpCalField}, 8'h03);
        wr(6'h2e, 8'h22);
        chk({7'h0, vcoSelectionCalEnable}, 8'h01);
        chk({6'h0, chargePumpCalField}, 8'h02);
        rd(6'h2e, 8'h22);
        $display("test byte fields done");
        for (int k = 0; k < 2; k++) begin
            wr(6'h29, 8'h11);
            wr(6'h2c, 8'h22);
            wr(6'h2d, 8'h33);
            chk(wakeHiAnalog, 8'h22);
            chk(wakeLoAnalog, 8'h33);
            @(negedge core_clk);
            sleepActive = 1'b1;
            converterKeepOption = k[0];
            wr(6'h2a, 8'h00);
            chk(analogTrimB, 8'h7f);
            @(negedge core_clk);
            sleepActive = 1'b0;
            regReq.write = 1'b1;
            regReq.addr = 6'h2d;
            regReq.wdata = 8'h00;
            @(negedge core_clk);
            regReq.write = 1'b0;
            // read straight after the wake cycle
            regReq.read = 1'b1;
            regReq.addr = 6'h2c;
            chk(wakeHiAnalog, k ? 8'h81 : 8'h88);
            chk(wakeLoAnalog, k ? 8'h35 : 8'h31);
            chk(analogTrimA, 8'h59);
            chk(vcoSelectCalSetting, 8'h0b);
            chk({2'h0, vcoCoarseCap}, 8'h3f);
            chk(analogTrimC, 8'h3f);
            @(negedge core_clk);
            regReq.read = 1'b0;
            chk({7'h0, regRsp.valid}, 8'h01);
            chk(regRsp.data, 8'h88);
            rd(6'h2c, 8'h88);
            rd(6'h2d, 8'h31);
            wr(6'h2c, 8'h5a);
            chk(wakeHiAnalog, 8'h5a);
            rd(6'h2c, 8'h5a);
            $display("wake with keep option %0d done", k);
        end
        stop_test();
    end
endmodule : synth_cal_test_regs_tb
